// ==== common/mtm_pkg.sv ====
package mtm_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_TABLE_COMMAND         = 16'h1800;
  localparam logic [15:0] IDX_TABLE_WRITE_DATA_LOW  = 16'h1801;
  localparam logic [15:0] IDX_TABLE_WRITE_DATA_HIGH = 16'h1802;
  localparam logic [15:0] IDX_TABLE_READ_DATA_LOW   = 16'h1805;
  localparam logic [15:0] IDX_TABLE_READ_DATA_HIGH  = 16'h1806;
  localparam logic [15:0] IDX_TABLE_COMMAND_STATUS  = 16'h1808;
  localparam logic [15:0] IDX_GLOBAL_INGRESS_CONFIG = 16'h1809;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CMD_MAKE_BIT        = 2;
  localparam int CMD_FIRST_BIT       = 1;
  localparam int CMD_NEXT_BIT        = 0;
  localparam int CMD_W               = 3;
  localparam int HI_VALID_BIT        = 24;
  localparam int HI_AGE_BIT          = 23;
  localparam int HI_STATIC_BIT       = 22;
  localparam int HI_FILTER_BIT       = 21;
  localparam int HI_PRIO_MSB         = 20;
  localparam int HI_PRIO_LSB         = 19;
  localparam int HI_PORT_MSB         = 18;
  localparam int HI_PORT_LSB         = 16;
  localparam int HI_MAC_MSB          = 15;
  localparam int HI_W                = 25;
  localparam int STS_MAKE_PEND_BIT   = 0;
  localparam int STS_SEARCH_PEND_BIT = 1;
  localparam int STS_END_BIT         = 2;
  localparam int GCFG_DA_PRIO_BIT    = 5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [CMD_W-1:0] RST_TABLE_COMMAND  = 3'h0;
  localparam logic [31:0]      RST_WRITE_DATA_LOW = 32'h0000_0000;
  localparam logic [HI_W-1:0]  RST_WRITE_DATA_HI  = 25'h000_0000;
  localparam logic [31:0]      RST_READ_DATA_LOW  = 32'h0000_0000;
  localparam logic [HI_W-1:0]  RST_READ_DATA_HI   = 25'h000_0000;

  // ----------------------------------------------------------------------
  // timing: aging sweep period; idle entries go after one to two sweeps
  // ----------------------------------------------------------------------
  localparam longint AGE_SWEEP_S     = 300;
  localparam longint CLK_HZ          = 100_000_000;
  localparam logic [35:0] AGE_SWEEP_CYCLES = 36'(AGE_SWEEP_S * CLK_HZ);

  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH} mtm_state_type;

endpackage : mtm_pkg

// ==== hdl/mtm_table_access.sv ====
// Functional notes
// - make-entry stores staged write data into table
// - make-entry can modify or remove existing entries
// - writing zero to command bits does nothing
// - get-first restarts pointer, loads first valid entry
// - get-next loads the next valid entry
// - low write data holds first 32 address bits
// - valid bit set validates, clear invalidates entry
// - static plus override forwards ignoring port state
// - static entries never age; others age 5-10 minutes
// - inactivity means no matching source address seen
// - filter bit drops matching destination packets
// - priority applies when static and global enable
// - port field selects single port or port set
// - high write data bits 15:0 hold last address bits
// - read valid clears on command, sets on find
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps

module mtm_table_access
  import mtm_pkg::*;
#(
  parameter int          DEPTH      = 64,               // table entries
  parameter logic [35:0] AGE_CYCLES = AGE_SWEEP_CYCLES  // aging sweep period
)(
  input  wire logic        mclk,            // core clock
  input  wire logic        resetn,          // async reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write strobe
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready in
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // always okay
  output logic [31:0]      hrdata,          // read data
  input  wire logic        sa_valid,        // received source address strobe
  input  wire logic [47:0] sa_mac,          // received source address
  input  wire logic        da_valid,        // destination lookup request
  input  wire logic [47:0] da_mac,          // destination address
  output logic             da_hit,          // lookup found an entry
  output logic [2:0]       da_port_mask,    // destination ports, bit per port
  output logic             da_drop,         // filter the packet
  output logic             da_override,     // ignore port state
  output logic             da_prio_valid,   // priority applies
  output logic [1:0]       da_prio          // destination priority
);

  localparam int PW = $clog2(DEPTH) + 1;
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH);

  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  logic [47:0]      tbl_mac   [DEPTH];
  logic [8:0]       tbl_flags [DEPTH];    // {valid,age,static,filter,prio,port}
  logic [DEPTH-1:0] tbl_active;           // source seen since last sweep

  logic [CMD_W-1:0] cmd_reg;
  logic [31:0]      wr_lo_reg;
  logic [HI_W-1:0]  wr_hi_reg;
  logic [31:0]      rd_lo_reg;
  logic [HI_W-1:0]  rd_hi_reg;
  logic             end_reg;
  logic             da_prio_en_reg;
  logic             make_pend_reg, make_pend_next;
  logic             first_pend_reg, first_pend_next;
  logic             next_pend_reg, next_pend_next;
  mtm_state_type    state_reg;
  logic [PW-1:0]    ptr_reg;
  logic [35:0]      age_cnt_reg;
  logic             age_tick_reg;
  logic             dp_wr_reg, rd_late_reg;
  logic [15:0]      dp_idx_reg;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire              addr_phase = hsel & htrans[1] & hready;
  wire              in_space   = (haddr[31:18] == 14'h0000);
  wire [15:0]       rd_idx     = rd_late_reg ? dp_idx_reg : haddr[17:2];
  wire              rd_now     = (addr_phase & ~hwrite & ~(dp_wr_reg & in_space)) | rd_late_reg;
  wire              wr_cmd     = dp_wr_reg & (dp_idx_reg == IDX_TABLE_COMMAND);
  wire              wr_lo      = dp_wr_reg & (dp_idx_reg == IDX_TABLE_WRITE_DATA_LOW);
  wire              wr_hi      = dp_wr_reg & (dp_idx_reg == IDX_TABLE_WRITE_DATA_HIGH);
  wire              wr_gcfg    = dp_wr_reg & (dp_idx_reg == IDX_GLOBAL_INGRESS_CONFIG);

  // only a 0-to-1 transition of a command bit starts anything
  wire [CMD_W-1:0]  cmd_rise   = wr_cmd ? (hwdata[CMD_W-1:0] & ~cmd_reg) : '0;
  wire              make_start  = cmd_rise[CMD_MAKE_BIT];
  wire              first_start = cmd_rise[CMD_FIRST_BIT];
  wire              next_start  = cmd_rise[CMD_NEXT_BIT];

  wire [2:0]        sts_word   = {end_reg,
                                  first_pend_reg | next_pend_reg | (state_reg == ST_SEARCH),
                                  make_pend_reg};

  // read mux; unmapped words read as zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (rd_idx == IDX_TABLE_COMMAND)         rd_mux[CMD_W-1:0] = cmd_reg;
    if (rd_idx == IDX_TABLE_WRITE_DATA_LOW)  rd_mux = wr_lo_reg;
    if (rd_idx == IDX_TABLE_WRITE_DATA_HIGH) rd_mux[HI_W-1:0] = wr_hi_reg;
    if (rd_idx == IDX_TABLE_READ_DATA_LOW)   rd_mux = rd_lo_reg;
    if (rd_idx == IDX_TABLE_READ_DATA_HIGH)  rd_mux[HI_W-1:0] = rd_hi_reg;
    if (rd_idx == IDX_TABLE_COMMAND_STATUS)  rd_mux[2:0] = sts_word;
    if (rd_idx == IDX_GLOBAL_INGRESS_CONFIG) rd_mux[GCFG_DA_PRIO_BIT] = da_prio_en_reg;
    if (!rd_late_reg && !in_space)           rd_mux = 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // bus slave flops
  // ----------------------------------------------------------------------
  // a read right behind a write waits one cycle so it sees the new value
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      dp_wr_reg   <= 1'b0;
      rd_late_reg <= 1'b0;
      dp_idx_reg  <= 16'h0000;
    end
    else
    begin
      dp_wr_reg   <= addr_phase & hwrite & in_space;
      rd_late_reg <= addr_phase & ~hwrite & dp_wr_reg & in_space;
      hreadyout   <= ~(addr_phase & ~hwrite & dp_wr_reg & in_space);
      if (addr_phase)
        dp_idx_reg <= haddr[17:2];
      if (rd_now)
        hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_reg        <= RST_TABLE_COMMAND;
      wr_lo_reg      <= RST_WRITE_DATA_LOW;
      wr_hi_reg      <= RST_WRITE_DATA_HI;
      da_prio_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_cmd)  cmd_reg <= hwdata[CMD_W-1:0];
      if (wr_lo)   wr_lo_reg <= hwdata;
      if (wr_hi)   wr_hi_reg <= hwdata[HI_W-1:0];
      if (wr_gcfg) da_prio_en_reg <= hwdata[GCFG_DA_PRIO_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // per-entry address compares
  // ----------------------------------------------------------------------
  wire [47:0]       stage_mac = {wr_hi_reg[HI_MAC_MSB:0], wr_lo_reg};
  logic [DEPTH-1:0] mk_match, sa_match, da_match, free_slot;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_cmp
      assign mk_match[g]  = tbl_flags[g][8] & (tbl_mac[g] == stage_mac);
      assign sa_match[g]  = sa_valid & tbl_flags[g][8] & (tbl_mac[g] == sa_mac);
      assign da_match[g]  = da_valid & tbl_flags[g][8] & (tbl_mac[g] == da_mac);
      assign free_slot[g] = ~tbl_flags[g][8];
    end
  endgenerate

  // lowest matching, free and looked-up slots
  logic [PW-1:0] mk_idx, free_idx, da_idx;
  always_comb
  begin
    mk_idx   = '0;
    free_idx = '0;
    da_idx   = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (mk_match[i])  mk_idx   = PW'(i);
      if (free_slot[i]) free_idx = PW'(i);
      if (da_match[i])  da_idx   = PW'(i);
    end
  end

  // the table picks the slot: an existing entry of that address first,
  // else the lowest free slot; a new entry is dropped when the table is full
  wire           commit    = (state_reg == ST_IDLE) & make_pend_reg;
  wire           commit_we = commit & ((|mk_match) | (wr_hi_reg[HI_VALID_BIT] & (|free_slot)));
  wire [PW-1:0]  commit_idx = (|mk_match) ? mk_idx : free_idx;
  wire [8:0]     stage_flags = wr_hi_reg[HI_VALID_BIT:HI_PORT_LSB];

  // ----------------------------------------------------------------------
  // aging tick divider
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      age_cnt_reg  <= 36'h0_0000_0000;
      age_tick_reg <= 1'b0;
    end
    else
    begin
      age_tick_reg <= (age_cnt_reg == AGE_CYCLES - 36'h0_0000_0001);
      if (age_cnt_reg == AGE_CYCLES - 36'h0_0000_0001)
        age_cnt_reg <= 36'h0_0000_0000;
      else
        age_cnt_reg <= age_cnt_reg + 36'h0_0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // table storage: commit, aging sweep and activity marks
  // ----------------------------------------------------------------------
  // a non-static entry idle for a whole sweep is dropped at the next tick
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        tbl_mac[i]   <= 48'h0000_0000_0000;
        tbl_flags[i] <= 9'h000;
      end
      tbl_active <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (commit_we && commit_idx == PW'(i))
        begin
          tbl_mac[i]    <= stage_mac;
          tbl_flags[i]  <= stage_flags;
          tbl_active[i] <= 1'b1;   // full sweep before aging starts
        end
        else if (age_tick_reg && tbl_flags[i][8] && !tbl_flags[i][6])
        begin
          if (tbl_active[i] || sa_match[i])
            tbl_active[i] <= 1'b0;
          else
            tbl_flags[i][8] <= 1'b0;
        end
        else if (sa_match[i])
          tbl_active[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------------
  // set wins over clear on every pending flag
  assign make_pend_next  = make_start | (make_pend_reg & ~commit);
  assign first_pend_next = first_start | (first_pend_reg &
                           ~((state_reg == ST_IDLE) & ~make_pend_reg));
  assign next_pend_next  = next_start | (next_pend_reg &
                           ~((state_reg == ST_IDLE) & ~make_pend_reg & ~first_pend_reg));

  wire [PW-2:0]  scan_idx   = ptr_reg[PW-2:0];
  wire           scan_valid = (ptr_reg != LAST_PTR) & tbl_flags[scan_idx][8];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      make_pend_reg  <= 1'b0;
      first_pend_reg <= 1'b0;
      next_pend_reg  <= 1'b0;
      state_reg      <= ST_IDLE;
      ptr_reg        <= '0;
      rd_lo_reg      <= RST_READ_DATA_LOW;
      rd_hi_reg      <= RST_READ_DATA_HI;
      end_reg        <= 1'b0;
    end
    else
    begin
      make_pend_reg  <= make_pend_next;
      first_pend_reg <= first_pend_next;
      next_pend_reg  <= next_pend_next;
      if (first_start || next_start)
      begin
        rd_hi_reg[HI_VALID_BIT] <= 1'b0;
        end_reg                 <= 1'b0;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (!make_pend_reg && first_pend_reg)
          begin
            ptr_reg   <= '0;
            state_reg <= ST_SEARCH;
          end
          else if (!make_pend_reg && next_pend_reg)
            state_reg <= ST_SEARCH;
        end
        ST_SEARCH:
        begin
          if (ptr_reg == LAST_PTR)
          begin
            end_reg   <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else
          begin
            ptr_reg <= ptr_reg + PW'(1);
            if (scan_valid)
            begin
              rd_lo_reg <= tbl_mac[scan_idx][31:0];
              rd_hi_reg <= {1'b1, tbl_flags[scan_idx][7:0],
                            tbl_mac[scan_idx][47:32]};
              state_reg <= ST_IDLE;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // destination lookup results, one cycle after the request
  // ----------------------------------------------------------------------
  wire [8:0] hit_flags = tbl_flags[da_idx[PW-2:0]];
  logic [2:0] port_mask;
  always_comb
  begin
    case (hit_flags[2:0])
      3'b000:  port_mask = 3'b001;
      3'b001:  port_mask = 3'b010;
      3'b010:  port_mask = 3'b100;
      3'b100:  port_mask = 3'b011;
      3'b101:  port_mask = 3'b101;
      3'b110:  port_mask = 3'b110;
      3'b111:  port_mask = 3'b111;
      default: port_mask = 3'b000;          // reserved code selects nothing
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      da_hit        <= 1'b0;
      da_port_mask  <= 3'b000;
      da_drop       <= 1'b0;
      da_override   <= 1'b0;
      da_prio_valid <= 1'b0;
      da_prio       <= 2'b00;
    end
    else
    begin
      da_hit        <= |da_match;
      da_port_mask  <= (|da_match) ? port_mask : 3'b000;
      da_drop       <= (|da_match) & hit_flags[5];
      da_override   <= (|da_match) & hit_flags[6] & hit_flags[7];
      da_prio_valid <= (|da_match) & hit_flags[6] & da_prio_en_reg;
      da_prio       <= (|da_match) ? hit_flags[4:3] : 2'b00;
    end
  end

endmodule : mtm_table_access

// ==== verification/mtm_table_access_asserts.sv ====
`timescale 1ns/100ps

module mtm_table_access_asserts
  import mtm_pkg::*;
#(
  parameter int          DEPTH      = 64,               // table entries
  parameter logic [35:0] AGE_CYCLES = AGE_SWEEP_CYCLES  // aging sweep period
)(
  input wire logic        mclk,          // core clock
  input wire logic        resetn,        // async reset, active low
  input wire logic        hsel,          // slave select
  input wire logic [31:0] haddr,         // byte address
  input wire logic [1:0]  htrans,        // transfer type
  input wire logic        hwrite,        // write strobe
  input wire logic [2:0]  hsize,         // transfer size
  input wire logic [31:0] hwdata,        // write data
  input wire logic        hready,        // bus ready in
  input wire logic        hreadyout,     // slave ready
  input wire logic        hresp,         // response
  input wire logic [31:0] hrdata,        // read data
  input wire logic        sa_valid,      // source address strobe
  input wire logic [47:0] sa_mac,        // source address
  input wire logic        da_valid,      // lookup request
  input wire logic [47:0] da_mac,        // lookup address
  input wire logic        da_hit,        // lookup hit
  input wire logic [2:0]  da_port_mask,  // destination ports
  input wire logic        da_drop,       // filter packet
  input wire logic        da_override,   // ignore port state
  input wire logic        da_prio_valid, // priority applies
  input wire logic [1:0]  da_prio        // destination priority
);
  // ----------------------------------------------------------------------
  // bus phase decode, shared by the properties below
  // ----------------------------------------------------------------------
  wire taken_wr = hsel & htrans[1] & hready & hwrite;
  wire taken_rd = hsel & htrans[1] & hready & ~hwrite;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response was not okay");
  a_write_no_wait: assert property (taken_wr |=> hreadyout)
    else $error("write was stalled");
  a_stall_single: assert property (!hreadyout |=> hreadyout)
    else $error("stall lasted more than one cycle");
  // a stall is only allowed for a read that overlaps a write data phase
  a_stall_cause: assert property (!hreadyout |-> $past(taken_rd) && $past(taken_wr, 2))
    else $error("stall without a read after a write");
  a_read_zero_wait: assert property (taken_rd && !$past(taken_wr) |=> hreadyout)
    else $error("plain read was stalled");
  a_rdata_stands: assert property (!$past(taken_rd) && !$past(taken_rd, 2) |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_miss_quiet: assert property (
    !da_hit |-> da_port_mask == 3'h0 && !da_drop && !da_override && !da_prio_valid
      && da_prio == 2'h0)
    else $error("lookup outputs set without a hit");
  a_hit_cause: assert property (da_hit |-> $past(da_valid))
    else $error("hit without a lookup request");
endmodule : mtm_table_access_asserts

bind mtm_table_access mtm_table_access_asserts #(
  .DEPTH      (DEPTH),
  .AGE_CYCLES (AGE_CYCLES)
) u_asserts (
  .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sa_valid(sa_valid),
  .sa_mac(sa_mac), .da_valid(da_valid), .da_mac(da_mac), .da_hit(da_hit),
  .da_port_mask(da_port_mask), .da_drop(da_drop), .da_override(da_override),
  .da_prio_valid(da_prio_valid), .da_prio(da_prio)
);

// ==== verification/mtm_table_access_bench.sv ====
`timescale 1ns/100ps

module mtm_table_access_bench;
  import mtm_pkg::*;
  localparam logic [35:0] AGE_T = 36'h0_0000_00c8; // short sweep keeps the run brief
  localparam logic [47:0] MAC_A = 48'h0a0b_0c0d_0e0f;
  localparam logic [47:0] MAC_B = 48'h1111_2222_3333;
  localparam logic [47:0] MAC_C = 48'h4444_5555_6666;
  localparam logic [47:0] MAC_D = 48'h7777_8888_9999;
  logic        mclk, resetn, hsel, hwrite, hreadyout, hresp, sa_valid, da_valid;
  logic        da_hit, da_drop, da_override, da_prio_valid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, da_prio;
  logic [2:0]  hsize, da_port_mask;
  logic [47:0] sa_mac, da_mac;
  int          fail_count, tests_run;

  // single slave, so its ready is the bus ready
  mtm_table_access #(.DEPTH(8), .AGE_CYCLES(AGE_T)) u_dut (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sa_valid(sa_valid),
    .sa_mac(sa_mac), .da_valid(da_valid), .da_mac(da_mac), .da_hit(da_hit),
    .da_port_mask(da_port_mask), .da_drop(da_drop), .da_override(da_override),
    .da_prio_valid(da_prio_valid), .da_prio(da_prio)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // shared bus and compare tasks; all are entered just after a clock edge
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 16);
    check(32'(n < 16), 32'h0000_0001);
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {14'h0000, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, idx, 32'h0000_0000, x);
    check(x, exp);
  endtask : rd_chk

  // status flags are polled, never assumed to clear in a fixed time
  task automatic poll(input int b);
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, IDX_TABLE_COMMAND_STATUS, 32'h0000_0000, s);
      n++;
    end
    while (s[b] !== 1'b0 && n < 40);
    check(32'(s[b]), 32'h0000_0000);
  endtask : poll

  task automatic make(input logic [47:0] m, input logic [31:0] hi);
    wr(IDX_TABLE_WRITE_DATA_LOW, m[31:0]);
    wr(IDX_TABLE_WRITE_DATA_HIGH, hi);
    wr(IDX_TABLE_COMMAND, 32'h0000_0004);
    poll(STS_MAKE_PEND_BIT);
    wr(IDX_TABLE_COMMAND, 32'h0000_0000);
  endtask : make

  task automatic look(input logic [47:0] m, input logic [8:0] e);
    da_valid <= 1'b1;
    da_mac   <= m;
    @(posedge mclk);
    da_valid <= 1'b0;
    @(posedge mclk);
    check({23'h00_0000, da_hit, da_port_mask, da_drop, da_override, da_prio_valid, da_prio},
          {23'h00_0000, e});
  endtask : look

  function automatic logic [31:0] hw(logic v, logic ag, logic st, logic fl, logic [1:0] pr,
                                     logic [2:0] pt, logic [15:0] m);
    return {7'h00, v, ag, st, fl, pr, pt, m};
  endfunction : hw

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rd_chk(IDX_TABLE_WRITE_DATA_LOW, 32'h0000_0000);
    rd_chk(IDX_TABLE_WRITE_DATA_HIGH, 32'h0000_0000);
    rd_chk(IDX_TABLE_COMMAND, 32'h0000_0000);
    rd_chk(IDX_TABLE_COMMAND_STATUS, 32'h0000_0000);
    wr(IDX_TABLE_WRITE_DATA_LOW, 32'hdead_beef);
    rd_chk(IDX_TABLE_WRITE_DATA_LOW, 32'hdead_beef);
    wr(IDX_TABLE_WRITE_DATA_HIGH, 32'hffff_ffff);
    rd_chk(IDX_TABLE_WRITE_DATA_HIGH, 32'h01ff_ffff);
    wr(16'h1803, 32'h1234_5678);
    rd_chk(16'h1803, 32'h0000_0000);
    // write data phase overlapped by a read of the same word: one stall
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr  <= {14'h0000, IDX_TABLE_WRITE_DATA_LOW, 2'h0};
    wait_rdy();
    hwdata <= 32'h0bad_cafe;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    wait_rdy();
    check(hrdata, 32'h0bad_cafe);
    $display("test registers done");
  endtask : t_regs

  task automatic t_make;
    make(MAC_A, hw(1'h1, 1'h0, 1'h1, 1'h1, 2'h2, 3'h5, MAC_A[47:32]));
    look(MAC_A, {1'h1, 3'h5, 1'h1, 1'h0, 1'h0, 2'h2});
    wr(IDX_GLOBAL_INGRESS_CONFIG, 32'(1) << GCFG_DA_PRIO_BIT);
    look(MAC_A, {1'h1, 3'h5, 1'h1, 1'h0, 1'h1, 2'h2});
    // staged data with a zero command write must not reach the table
    wr(IDX_TABLE_WRITE_DATA_LOW, MAC_B[31:0]);
    wr(IDX_TABLE_WRITE_DATA_HIGH, hw(1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 3'h0, MAC_B[47:32]));
    wr(IDX_TABLE_COMMAND, 32'h0000_0000);
    rd_chk(IDX_TABLE_COMMAND_STATUS, 32'h0000_0000);
    look(MAC_B, 9'h000);
    $display("test make done");
  endtask : t_make

  task automatic t_modify;
    logic [2:0] mk [8];
    mk = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 8; i++)
    begin
      make(MAC_A, hw(1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 3'(i), MAC_A[47:32]));
      look(MAC_A, {1'h1, mk[i], 1'h0, 1'h1, 1'h1, 2'h0});
    end
    make(MAC_A, hw(1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0, MAC_A[47:32]));
    look(MAC_A, 9'h000);
    $display("test modify done");
  endtask : t_modify

  task automatic t_walk;
    logic [31:0] x;
    make(MAC_B, hw(1'h1, 1'h0, 1'h1, 1'h0, 2'h1, 3'h1, MAC_B[47:32]));
    make(MAC_C, hw(1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 3'h2, MAC_C[47:32]));
    wr(IDX_TABLE_COMMAND, 32'h0000_0002);
    poll(STS_SEARCH_PEND_BIT);
    rd_chk(IDX_TABLE_READ_DATA_LOW, MAC_B[31:0]);
    rd_chk(IDX_TABLE_READ_DATA_HIGH, hw(1'h1, 1'h0, 1'h1, 1'h0, 2'h1, 3'h1, MAC_B[47:32]));
    wr(IDX_TABLE_COMMAND, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_TABLE_COMMAND, 32'h0000_0001);
      poll(STS_SEARCH_PEND_BIT);
      xfer(1'b0, IDX_TABLE_READ_DATA_LOW, 32'h0000_0000, x);
      if (i == 0)
        check(x, MAC_C[31:0]);
      xfer(1'b0, IDX_TABLE_READ_DATA_HIGH, 32'h0000_0000, x);
      check(32'(x[HI_VALID_BIT]), 32'(i == 0));
      wr(IDX_TABLE_COMMAND, 32'h0000_0000);
    end
    xfer(1'b0, IDX_TABLE_COMMAND_STATUS, 32'h0000_0000, x);
    check(32'(x[STS_END_BIT]), 32'h0000_0001);
    $display("test walk done");
  endtask : t_walk

  task automatic t_age;
    make(MAC_C, hw(1'h1, 1'h1, 1'h0, 1'h0, 2'h0, 3'h2, MAC_C[47:32]));
    make(MAC_D, hw(1'h1, 1'h1, 1'h0, 1'h0, 2'h3, 3'h1, MAC_D[47:32]));
    // keep only the second address active across more than two sweeps
    for (int i = 0; i < 10; i++)
    begin
      repeat (50) @(posedge mclk);
      sa_valid <= 1'b1;
      sa_mac   <= MAC_D;
      @(posedge mclk);
      sa_valid <= 1'b0;
    end
    look(MAC_B, {1'h1, 3'h2, 1'h0, 1'h0, 1'h1, 2'h1});
    look(MAC_C, 9'h000);
    look(MAC_D, {1'h1, 3'h2, 1'h0, 1'h0, 1'h0, 2'h3});
    $display("test aging done");
  endtask : t_age

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    {resetn, hsel, hwrite, sa_valid, da_valid} = 5'h00;
    {haddr, hwdata, sa_mac, da_mac} = '0;
    htrans = 2'h0;
    hsize  = 3'h2;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_make();
    t_modify();
    t_walk();
    t_age();
    close_out();
  end
endmodule : mtm_table_access_bench
